/* rtl/rx_ctrl_pkg.sv */
package rx_ctrl_pkg;

	// ------------------------------------------------------------
	// Register map (byte addresses)
	// ------------------------------------------------------------
	localparam int          ADDR_W          = 8;
	localparam logic [7:0]  LANE6_OFS       = 8'h1C;
	localparam logic [7:0]  LANE7_OFS       = 8'h20;
	localparam logic [7:0]  LINK_OFS        = 8'h50;
	localparam logic [7:0]  REINIT_EN_OFS   = 8'h78;
	localparam logic [7:0]  CFG_WORD0_OFS   = 8'hA0;
	localparam logic [7:0]  CFG_WORD1_OFS   = 8'hA4;
	localparam logic [7:0]  CFG_WORD2_OFS   = 8'hA8;
	localparam logic [7:0]  CFG_WORD3_OFS   = 8'hAC;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int          LANE_FIELD_LSB  = 0;
	localparam int          LANE_FIELD_MSB  = 2;
	localparam int          LINK_FIELD_LSB  = 7;
	localparam int          LINK_FIELD_MSB  = 16;
	localparam int          LINK_SEL_LSB    = 7;
	localparam int          LINK_SEL_MSB    = 10;
	localparam int          LINK_REINIT_POS = 12;

	// ------------------------------------------------------------
	// Sizes and reset values
	// ------------------------------------------------------------
	localparam int          NUM_LANES       = 8;
	localparam int          CFG_WORDS       = 4;
	localparam int          ERR_KINDS       = 8;
	localparam int          CODE_GROUP_IDX  = 0;
	localparam logic [3:0]  LAST_LANE_SEL   = 4'h7;
	localparam logic [2:0]  LANE_RESET      = 3'h4;
	localparam logic [9:0]  LINK_RESET      = 10'h000;
	localparam logic [7:0]  REINIT_EN_RESET = 8'hFF;

	// Per-lane control word, bit 2 down to bit 0
	typedef struct packed {
		logic       spare;
		logic       power_off;
		logic       invert;
	} lane_ctrl_s;

	// Link control word, bit 16 down to bit 7
	typedef struct packed {
		logic [3:0] spare_hi;
		logic       reinit_off;
		logic       spare_lo;
		logic [3:0] cfg_sel;
	} link_ctrl_s;

	// Register port request
	typedef struct packed {
		logic [7:0]  addr;
		logic [31:0] wdata;
		logic        wr;
		logic        rd;
	} reg_req_s;

endpackage

/* rtl/lane_invert.sv */
`timescale 1ns/1ps
module lane_invert #(
	parameter int DATA_W = 32
) (
	input  wire logic              core_clk,
	input  wire logic              nrst,
	input  wire logic              invert,
	input  wire logic [DATA_W-1:0] din,
	output logic      [DATA_W-1:0] dout
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (DATA_W < 1) begin : g_bad_width
		$error("lane_invert: DATA_W must be at least 1");
	end

	logic [DATA_W-1:0] next_dout;

	// Flip every bit when swapped pairs are flagged
	always_comb begin
		next_dout = invert ? ~din : din;
	end

	// Register the lane data, one cycle of latency
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			dout <= '0;
		end else begin
			dout <= next_dout;
		end
	end

endmodule // lane_invert

/* rtl/cfg_capture.sv */
`timescale 1ns/1ps
module cfg_capture #(
	parameter int LANES = 8,
	parameter int WORDS = 4
) (
	input  wire logic                           core_clk,
	input  wire logic                           nrst,
	input  wire logic [LANES-1:0]               capture,
	input  wire logic [LANES-1:0][WORDS*32-1:0] cfg_in,
	input  wire logic [3:0]                     sel,
	output logic      [WORDS*32-1:0]            sel_words
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (LANES < 1 || LANES > 16 || WORDS < 1) begin : g_bad_size
		$error("cfg_capture: LANES must be 1..16 and WORDS at least 1");
	end

	logic [WORDS*32-1:0] store      [LANES];
	logic [WORDS*32-1:0] next_store [LANES];

	// Each lane keeps its own copy until its next capture
	always_comb begin
		for (int i = 0; i < LANES; i++) begin
			next_store[i] = capture[i] ? cfg_in[i] : store[i];
		end
	end

	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			for (int i = 0; i < LANES; i++) begin
				store[i] <= '0;
			end
		end else begin
			for (int i = 0; i < LANES; i++) begin
				store[i] <= next_store[i];
			end
		end
	end

	// Out-of-range selection yields all zeros
	always_comb begin
		sel_words = '0;
		for (int i = 0; i < LANES; i++) begin
			if (sel == 4'(i)) begin
				sel_words = store[i];
			end
		end
	end

endmodule // cfg_capture

/* rtl/rx_lane_link_regs.sv */
`timescale 1ns/1ps
module rx_lane_link_regs #(
	parameter int DATA_W    = 32,
	parameter int ERR_KINDS = rx_ctrl_pkg::ERR_KINDS
) (
	input  wire logic                                        core_clk,
	input  wire logic                                        nrst,
	input  wire logic [7:0]                                  reg_addr,
	input  wire logic [31:0]                                 reg_wdata,
	input  wire logic                                        reg_wr,
	input  wire logic                                        reg_rd,
	output logic      [31:0]                                 reg_rdata,
	output logic      [7:6]                                  lane_power_off,
	input  wire logic [DATA_W-1:0]                           lane6_rx_in,
	input  wire logic [DATA_W-1:0]                           lane7_rx_in,
	output logic      [DATA_W-1:0]                           lane6_rx_out,
	output logic      [DATA_W-1:0]                           lane7_rx_out,
	input  wire logic [rx_ctrl_pkg::NUM_LANES-1:0]           cfg_capture_in,
	input  wire logic [rx_ctrl_pkg::NUM_LANES-1:0][127:0]    cfg_words_in,
	input  wire logic [ERR_KINDS-1:0]                        link_err,
	output logic                                             link_reinit
);

	// ------------------------------------------------------------
	// Parameter check
	// ------------------------------------------------------------
	if (ERR_KINDS < 1 || ERR_KINDS > 32) begin : g_bad_errs
		$error("rx_lane_link_regs: ERR_KINDS must be 1..32");
	end
	if (rx_ctrl_pkg::CFG_WORDS != 4) begin : g_bad_words
		$error("rx_lane_link_regs: four config words expected");
	end
	if (DATA_W < 1) begin : g_bad_data
		$error("rx_lane_link_regs: DATA_W must be at least 1");
	end
	if (rx_ctrl_pkg::CODE_GROUP_IDX >= ERR_KINDS) begin : g_bad_code_group
		$error("rx_lane_link_regs: code-group error bit outside link_err");
	end
	if (rx_ctrl_pkg::NUM_LANES < 8) begin : g_bad_lanes
		$error("rx_lane_link_regs: lanes 6 and 7 need at least eight lanes");
	end
	if (rx_ctrl_pkg::ADDR_W != 8) begin : g_bad_addr
		$error("rx_lane_link_regs: register port address is eight bits");
	end
	if (rx_ctrl_pkg::LINK_SEL_MSB - rx_ctrl_pkg::LINK_SEL_LSB != 3) begin : g_bad_sel
		$error("rx_lane_link_regs: lane selector must be four bits");
	end
	if (rx_ctrl_pkg::LINK_REINIT_POS - rx_ctrl_pkg::LINK_FIELD_LSB != 5) begin : g_bad_reinit_pos
		$error("rx_lane_link_regs: reinit disable position does not match struct");
	end

	// ------------------------------------------------------------
	// Helpers
	// ------------------------------------------------------------

	// Place a lane word in the low bits, upper bits zero
	function automatic logic [31:0] lane_word(input rx_ctrl_pkg::lane_ctrl_s c);
		lane_word = {29'h0000000, c};
	endfunction

	// Take the writable lane field out of a bus word
	function automatic rx_ctrl_pkg::lane_ctrl_s lane_field(input logic [31:0] w);
		lane_field = rx_ctrl_pkg::lane_ctrl_s'(
			w[rx_ctrl_pkg::LANE_FIELD_MSB:rx_ctrl_pkg::LANE_FIELD_LSB]);
	endfunction

	// Pick one word of the selected lane's config block
	function automatic logic [31:0] cfg_word(input logic [127:0] blk, input int idx);
		cfg_word = blk[idx*32 +: 32];
	endfunction

	// Take the writable link field (bits 16:7) out of a bus word
	function automatic rx_ctrl_pkg::link_ctrl_s link_field(input logic [31:0] w);
		link_field = rx_ctrl_pkg::link_ctrl_s'(
			w[rx_ctrl_pkg::LINK_FIELD_MSB:rx_ctrl_pkg::LINK_FIELD_LSB]);
	endfunction

	// Place the link field at bits 16:7; reserved bits read zero
	function automatic logic [31:0] link_word(input rx_ctrl_pkg::link_ctrl_s c);
		link_word = 32'h00000000;
		link_word[rx_ctrl_pkg::LINK_FIELD_MSB:rx_ctrl_pkg::LINK_FIELD_LSB] = c;
	endfunction

	// Per-error reinit gate; the global disable keeps only code-group,
	// still under its own enable so that path can be silenced too
	function automatic logic [ERR_KINDS-1:0] reinit_gate(
		input logic [ERR_KINDS-1:0] en,
		input logic                 off
	);
		reinit_gate = en;
		if (off) begin
			reinit_gate = '0;
			reinit_gate[rx_ctrl_pkg::CODE_GROUP_IDX] = en[rx_ctrl_pkg::CODE_GROUP_IDX];
		end
	endfunction

	// ------------------------------------------------------------
	// Register state
	// ------------------------------------------------------------
	rx_ctrl_pkg::reg_req_s   req;
	rx_ctrl_pkg::lane_ctrl_s lane6;
	rx_ctrl_pkg::lane_ctrl_s lane7;
	rx_ctrl_pkg::link_ctrl_s link;
	logic [ERR_KINDS-1:0]    reinit_en;
	rx_ctrl_pkg::lane_ctrl_s next_lane6;
	rx_ctrl_pkg::lane_ctrl_s next_lane7;
	rx_ctrl_pkg::link_ctrl_s next_link;
	logic [ERR_KINDS-1:0]    next_reinit_en;
	logic [31:0]             next_reg_rdata;
	logic [127:0]            sel_words;
	logic                    cfg_sel_ok;
	logic [127:0]            cfg_view;
	logic [ERR_KINDS-1:0]    err_gate;
	logic                    next_link_reinit;

	// Bundle the bus request
	always_comb begin
		req.addr  = reg_addr;
		req.wdata = reg_wdata;
		req.wr    = reg_wr;
		req.rd    = reg_rd;
	end

	// ------------------------------------------------------------
	// Write decode
	// ------------------------------------------------------------

	// Only the documented fields are stored; upper bits are dropped
	always_comb begin
		next_lane6     = lane6;
		next_lane7     = lane7;
		next_link      = link;
		next_reinit_en = reinit_en;
		if (req.wr) begin
			case (req.addr)
				rx_ctrl_pkg::LANE6_OFS: begin
					next_lane6 = lane_field(req.wdata);
				end
				rx_ctrl_pkg::LANE7_OFS: begin
					next_lane7 = lane_field(req.wdata);
				end
				rx_ctrl_pkg::LINK_OFS: begin
					next_link = link_field(req.wdata);
				end
				rx_ctrl_pkg::REINIT_EN_OFS: begin
					next_reinit_en = req.wdata[ERR_KINDS-1:0];
				end
				default: begin
					next_lane6 = lane6;
				end
			endcase
		end
	end

	// Control words: lane spares and the low eight reinit enables come up set, all else clear
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			lane6     <= rx_ctrl_pkg::lane_ctrl_s'(rx_ctrl_pkg::LANE_RESET);
			lane7     <= rx_ctrl_pkg::lane_ctrl_s'(rx_ctrl_pkg::LANE_RESET);
			link      <= rx_ctrl_pkg::link_ctrl_s'(rx_ctrl_pkg::LINK_RESET);
			reinit_en <= ERR_KINDS'(rx_ctrl_pkg::REINIT_EN_RESET);
		end else begin
			lane6     <= next_lane6;
			lane7     <= next_lane7;
			link      <= next_link;
			reinit_en <= next_reinit_en;
		end
	end

	// ------------------------------------------------------------
	// Read decode
	// ------------------------------------------------------------

	// Unmapped addresses read zero; data appears the cycle after
	always_comb begin
		next_reg_rdata = 32'h00000000;
		if (req.rd) begin
			case (req.addr)
				rx_ctrl_pkg::LANE6_OFS: begin
					next_reg_rdata = lane_word(lane6);
				end
				rx_ctrl_pkg::LANE7_OFS: begin
					next_reg_rdata = lane_word(lane7);
				end
				rx_ctrl_pkg::LINK_OFS: begin
					next_reg_rdata = link_word(link);
				end
				rx_ctrl_pkg::REINIT_EN_OFS: begin
					next_reg_rdata[ERR_KINDS-1:0] = reinit_en;
				end
				rx_ctrl_pkg::CFG_WORD0_OFS: begin
					next_reg_rdata = cfg_word(cfg_view, 0);
				end
				rx_ctrl_pkg::CFG_WORD1_OFS: begin
					next_reg_rdata = cfg_word(cfg_view, 1);
				end
				rx_ctrl_pkg::CFG_WORD2_OFS: begin
					next_reg_rdata = cfg_word(cfg_view, 2);
				end
				rx_ctrl_pkg::CFG_WORD3_OFS: begin
					next_reg_rdata = cfg_word(cfg_view, 3);
				end
				default: begin
					next_reg_rdata = 32'h00000000;
				end
			endcase
		end
	end

	// Read data stands for one cycle only, zero otherwise
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			reg_rdata <= 32'h00000000;
		end else begin
			reg_rdata <= next_reg_rdata;
		end
	end

	// ------------------------------------------------------------
	// Lane outputs
	// ------------------------------------------------------------

	// Straight from the stored bits so a fallback acts at once;
	// a downstream reset controller may use these as reset masks
	always_comb begin
		lane_power_off[6] = lane6.power_off;
		lane_power_off[7] = lane7.power_off;
	end

	// Per-lane polarity correction for swapped differential pairs
	lane_invert #(
		.DATA_W (DATA_W)
	) u_lane6_invert (
		.core_clk (core_clk),
		.nrst     (nrst),
		.invert   (lane6.invert),
		.din      (lane6_rx_in),
		.dout     (lane6_rx_out)
	);

	lane_invert #(
		.DATA_W (DATA_W)
	) u_lane7_invert (
		.core_clk (core_clk),
		.nrst     (nrst),
		.invert   (lane7.invert),
		.din      (lane7_rx_in),
		.dout     (lane7_rx_out)
	);

	// ------------------------------------------------------------
	// Link configuration capture
	// ------------------------------------------------------------

	// Every lane latches on its own strobe; selector picks the view
	cfg_capture #(
		.LANES (rx_ctrl_pkg::NUM_LANES),
		.WORDS (rx_ctrl_pkg::CFG_WORDS)
	) u_cfg_capture (
		.core_clk  (core_clk),
		.nrst      (nrst),
		.capture   (cfg_capture_in),
		.cfg_in    (cfg_words_in),
		.sel       (link.cfg_sel),
		.sel_words (sel_words)
	);

	// A selector past the last lane shows zeros here as well,
	// so a capture block built with spare lanes stays hidden
	always_comb begin
		cfg_sel_ok = link.cfg_sel <= rx_ctrl_pkg::LAST_LANE_SEL;
		cfg_view   = cfg_sel_ok ? sel_words : 128'h0;
	end

	// ------------------------------------------------------------
	// Link reinitialisation
	// ------------------------------------------------------------

	// Global disable leaves only the code-group error path open;
	// per-error enables still gate that one path
	always_comb begin
		err_gate = reinit_gate(reinit_en, link.reinit_off);
		next_link_reinit = |(link_err & err_gate);
	end

	// Registered so the request is glitch-free toward the link FSM
	always_ff @(posedge core_clk) begin
		if (!nrst) begin
			link_reinit <= 1'b0;
		end else begin
			link_reinit <= next_link_reinit;
		end
	end

endmodule // rx_lane_link_regs

/* testbench/rx_lane_link_regs_asserts.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register bank checker
// ------------------------------------------------------------
module rx_lane_link_regs_asserts #(
	parameter int DATA_W    = 32,
	parameter int ERR_KINDS = 8
) (
	input wire logic                                     core_clk,
	input wire logic                                     nrst,
	input wire logic [7:0]                               reg_addr,
	input wire logic [31:0]                              reg_wdata,
	input wire logic                                     reg_wr,
	input wire logic                                     reg_rd,
	input wire logic [31:0]                              reg_rdata,
	input wire logic [7:6]                               lane_power_off,
	input wire logic [DATA_W-1:0]                        lane6_rx_in,
	input wire logic [DATA_W-1:0]                        lane7_rx_in,
	input wire logic [DATA_W-1:0]                        lane6_rx_out,
	input wire logic [DATA_W-1:0]                        lane7_rx_out,
	input wire logic [rx_ctrl_pkg::NUM_LANES-1:0]        cfg_capture_in,
	input wire logic [rx_ctrl_pkg::NUM_LANES-1:0][127:0] cfg_words_in,
	input wire logic [ERR_KINDS-1:0]                     link_err,
	input wire logic                                     link_reinit
);
	logic [2:0]           l6, l7, next_l6, next_l7;
	logic [9:0]           lk, next_lk;
	logic [ERR_KINDS-1:0] en, next_en, gate;
	logic [31:0]          exp_rd;
	logic [DATA_W-1:0]    exp6, exp7;
	logic                 known, hit;

	// Shadow of the writable fields, reset folded in
	always_comb begin
		next_l6 = !nrst ? 3'h4 : l6;
		next_l7 = !nrst ? 3'h4 : l7;
		next_lk = !nrst ? 10'h000 : lk;
		next_en = !nrst ? '1 : en;
		if (nrst && reg_wr) begin
			case (reg_addr)
				rx_ctrl_pkg::LANE6_OFS: next_l6 = reg_wdata[2:0];
				rx_ctrl_pkg::LANE7_OFS: next_l7 = reg_wdata[2:0];
				rx_ctrl_pkg::LINK_OFS: next_lk = reg_wdata[16:7];
				rx_ctrl_pkg::REINIT_EN_OFS: next_en = reg_wdata[ERR_KINDS-1:0];
				default: ;
			endcase
		end
	end

	// Shadow registers
	always_ff @(posedge core_clk) begin
		l6 <= next_l6;
		l7 <= next_l7;
		lk <= next_lk;
		en <= next_en;
	end

	// Expected read word; config window left to the bench
	always_comb begin
		gate = lk[5] ? {{(ERR_KINDS-1){1'b0}}, en[0]} : en;
		hit = |(link_err & gate);
		exp6 = lane6_rx_in ^ {DATA_W{l6[0]}};
		exp7 = lane7_rx_in ^ {DATA_W{l7[0]}};
		known = reg_addr[7:4] != 4'hA;
		case (reg_addr)
			rx_ctrl_pkg::LANE6_OFS: exp_rd = {29'h0, l6};
			rx_ctrl_pkg::LANE7_OFS: exp_rd = {29'h0, l7};
			rx_ctrl_pkg::LINK_OFS: exp_rd = {15'h0, lk, 7'h0};
			rx_ctrl_pkg::REINIT_EN_OFS: exp_rd = 32'(en);
			default: exp_rd = 32'h0;
		endcase
	end

	default clocking cb @(posedge core_clk); endclocking
	default disable iff (!nrst);

	property p_pwr6;
		reg_wr && reg_addr == rx_ctrl_pkg::LANE6_OFS |=> lane_power_off[6] == $past(reg_wdata[1]);
	endproperty
	a_pwr6:
		assert property (p_pwr6) else $error("lane 6 power-down not following write");
	property p_pwr7;
		reg_wr && reg_addr == rx_ctrl_pkg::LANE7_OFS |=> lane_power_off[7] == $past(reg_wdata[1]);
	endproperty
	a_pwr7:
		assert property (p_pwr7) else $error("lane 7 power-down not following write");
	property p_rst_quiet;
		$rose(nrst) |-> lane_power_off == 2'h0 && !link_reinit && reg_rdata == 32'h0;
	endproperty
	a_rst_quiet:
		assert property (p_rst_quiet) else $error("outputs not quiet after reset");
	property p_rd_data;
		reg_rd && known |=> reg_rdata == $past(exp_rd);
	endproperty
	a_rd_data:
		assert property (p_rd_data) else $error("read data differs from stored fields");
	property p_rd_idle;
		!reg_rd |=> reg_rdata == 32'h0;
	endproperty
	a_rd_idle:
		assert property (p_rd_idle) else $error("read data outside the answer cycle");
	property p_inv;
		!reg_wr |=> lane6_rx_out == $past(exp6) && lane7_rx_out == $past(exp7);
	endproperty
	a_inv:
		assert property (p_inv) else $error("lane data polarity wrong");
	property p_reinit;
		!reg_wr |=> link_reinit == $past(hit);
	endproperty
	a_reinit:
		assert property (p_reinit) else $error("reinit request wrong for error input");
	property p_pwr_hold;
		!reg_wr |=> $stable(lane_power_off);
	endproperty
	a_pwr_hold:
		assert property (p_pwr_hold) else $error("power-down changed without a write");
endmodule // rx_lane_link_regs_asserts

bind rx_lane_link_regs rx_lane_link_regs_asserts #(.DATA_W(DATA_W), .ERR_KINDS(ERR_KINDS)) chk (
	.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
	.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_power_off(lane_power_off),
	.lane6_rx_in(lane6_rx_in), .lane7_rx_in(lane7_rx_in), .lane6_rx_out(lane6_rx_out),
	.lane7_rx_out(lane7_rx_out), .cfg_capture_in(cfg_capture_in),
	.cfg_words_in(cfg_words_in), .link_err(link_err), .link_reinit(link_reinit)
);

/* testbench/tb.sv */
`timescale 1ns/1ps
// ------------------------------------------------------------
// Register bank bench
// ------------------------------------------------------------
module tb;
	logic             core_clk = 1'b0;
	logic             nrst = 1'b0;
	logic [7:0]       reg_addr = 8'h00;
	logic [31:0]      reg_wdata = 32'h0, reg_rdata, seed = 32'hF76A0F9E;
	logic             reg_wr = 1'b0, reg_rd = 1'b0, link_reinit;
	logic [7:6]       lane_power_off;
	logic [31:0]      lane6_rx_in = 32'h0, lane7_rx_in = 32'h0, lane6_rx_out, lane7_rx_out;
	logic [7:0]       cfg_capture_in = 8'h00, link_err = 8'h00, men;
	logic [7:0][127:0] cfg_words_in = '0, cw;
	logic [2:0]       m6, m7;
	logic [9:0]       mlk;
	logic [7:0]       addrs [8] = '{8'h1C, 8'h20, 8'h50, 8'h78, 8'hA0, 8'h24, 8'hFC, 8'h50};
	int               bad_count = 0, n_checks = 0;

	// Free-running core clock
	always #5 core_clk = ~core_clk;

	rx_lane_link_regs dut (
		.core_clk(core_clk), .nrst(nrst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .lane_power_off(lane_power_off),
		.lane6_rx_in(lane6_rx_in), .lane7_rx_in(lane7_rx_in), .lane6_rx_out(lane6_rx_out),
		.lane7_rx_out(lane7_rx_out), .cfg_capture_in(cfg_capture_in),
		.cfg_words_in(cfg_words_in), .link_err(link_err), .link_reinit(link_reinit)
	);

	function automatic logic [31:0] lfsr(input logic [31:0] x);
		return {x[30:0], 1'b0} ^ (x[31] ? 32'h04C11DB7 : 32'h0);
	endfunction

	// Selector beyond lane 7 must read all zeros
	function automatic logic [31:0] exp_read(input logic [7:0] a);
		case (a)
			8'h1C: return {29'h0, m6};
			8'h20: return {29'h0, m7};
			8'h50: return {15'h0, mlk, 7'h0};
			8'h78: return {24'h0, men};
			8'hA0, 8'hA4, 8'hA8, 8'hAC: return mlk[3] ? 32'h0 : cw[mlk[2:0]][a[3:2]*32 +: 32];
			default: return 32'h0;
		endcase
	endfunction

	// Global disable leaves only the code-group bit
	function automatic logic exp_hit(input logic [7:0] e);
		return |(e & (mlk[5] ? {7'h0, men[0]} : men));
	endfunction

	task automatic check(input logic [31:0] got, input logic [31:0] exp);
		n_checks++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %0t got %h expected %h", $time, got, exp);
		end
	endtask

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge core_clk);
		reg_wr <= 1'b0;
		case (a)
			8'h1C: m6 = d[2:0];
			8'h20: m7 = d[2:0];
			8'h50: mlk = d[16:7];
			8'h78: men = d[7:0];
			default: ;
		endcase
		@(posedge core_clk);
	endtask

	task automatic rd(input logic [7:0] a);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge core_clk);
		reg_rd <= 1'b0;
		#1;
		check(reg_rdata, exp_read(a));
		@(posedge core_clk);
	endtask

	// One lane sample and one error pattern
	task automatic cyc(input logic [31:0] d, input logic [7:0] e);
		lane6_rx_in <= d;
		lane7_rx_in <= ~d;
		link_err <= e;
		@(posedge core_clk);
		#1;
		check(lane6_rx_out, d ^ {32{m6[0]}});
		check(lane7_rx_out, ~d ^ {32{m7[0]}});
		check({31'h0, link_reinit}, {31'h0, exp_hit(e)});
		check({30'h0, lane_power_off}, {30'h0, m7[1], m6[1]});
		@(posedge core_clk);
	endtask

	task automatic final_report;
		$display("checks %0d mismatches %0d", n_checks, bad_count);
		if (bad_count == 0 && n_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Hang guard
	initial begin
		repeat (50000) @(posedge core_clk);
		bad_count++;
		final_report;
	end

	// Main sequence
	initial begin
		m6 = 3'h4;
		m7 = 3'h4;
		mlk = 10'h000;
		men = 8'hFF;
		cw = '0;
		repeat (3) @(posedge core_clk);
		nrst <= 1'b1;
		@(posedge core_clk);
		foreach (addrs[i]) rd(addrs[i]);
		cyc(32'hA5A50F0F, 8'h02);
		$display("test reset done");
		for (int i = 0; i < 200; i++) begin
			seed = lfsr(seed);
			wr(addrs[seed[2:0]], lfsr(seed));
			seed = lfsr(seed);
			rd(addrs[seed[4:2]]);
			seed = lfsr(seed);
			cyc(seed, seed[15:8]);
		end
		$display("test random done");
		wr(8'h78, 32'hFF);
		wr(8'h50, 32'h00001000);
		cyc(32'h0, 8'hFE);
		cyc(32'h0, 8'h01);
		wr(8'h78, 32'hFE);
		cyc(32'h0, 8'h01);
		$display("test reinit done");
		for (int l = 0; l < 8; l++) begin
			for (int w = 0; w < 4; w++) begin
				seed = lfsr(seed);
				cw[l][w*32 +: 32] = seed;
			end
		end
		cfg_words_in <= cw;
		cfg_capture_in <= 8'hFF;
		@(posedge core_clk);
		cfg_words_in <= ~cw;
		cfg_capture_in <= 8'h08;
		cw[3] = ~cw[3];
		@(posedge core_clk);
		cfg_capture_in <= 8'h00;
		@(posedge core_clk);
		for (int s = 0; s < 16; s++) begin
			wr(8'h50, {21'h0, 4'(s), 7'h0});
			for (int k = 0; k < 4; k++) rd(8'hA0 + 8'(k * 4));
		end
		$display("test config done");
		final_report;
	end
endmodule // tb
